// ### rtl/dma_sel_pkg.sv
`default_nettype none
package dma_sel_pkg;

  // ------------------------
  // register offsets in the internal I/O space
  // ------------------------
  localparam logic [7:0] SRC0_LOW_OFS = 8'h20;
  localparam logic [7:0] SRC0_HIGH_OFS = 8'h21;
  localparam logic [7:0] SRC0_BANK_OFS = 8'h22;
  localparam logic [7:0] DST0_LOW_OFS = 8'h23;
  localparam logic [7:0] DST0_HIGH_OFS = 8'h24;
  localparam logic [7:0] DST0_BANK_OFS = 8'h25;
  localparam logic [7:0] CNT0_LOW_OFS = 8'h26;
  localparam logic [7:0] CNT0_HIGH_OFS = 8'h27;
  localparam logic [7:0] MEM1_LOW_OFS = 8'h28;
  localparam logic [7:0] MEM1_HIGH_OFS = 8'h29;
  localparam logic [7:0] MEM1_BANK_OFS = 8'h2a;
  localparam logic [7:0] IO1_LOW_OFS = 8'h2b;
  localparam logic [7:0] IO1_HIGH_OFS = 8'h2c;
  localparam logic [7:0] REQ_CTRL_OFS = 8'h2d;
  localparam logic [7:0] CNT1_LOW_OFS = 8'h2e;
  localparam logic [7:0] CNT1_HIGH_OFS = 8'h2f;

  // ------------------------
  // field layout
  // ------------------------
  localparam int BANK_BITS = 4;
  localparam int ADDR_BITS = 20;
  localparam int COUNT_BITS = 16;
  localparam int ALT_ENABLE_BIT = 7;
  localparam int ALT_CURRENT_BIT = 6;
  localparam int TOUT_SEL_BIT = 3;
  localparam int SEL_MSB = 2;

  // ------------------------
  // reset values
  // ------------------------
  localparam logic [7:0] ADDR_BYTE_RST = 8'h00;
  localparam logic [7:0] REQ_CTRL_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ------------------------
  // request select codes, shared by both channels
  // ------------------------
  typedef enum logic [2:0] {
    SEL_EXT_PIN = 3'b000,
    SEL_SERIAL0 = 3'b001,
    SEL_SERIAL1 = 3'b010,
    SEL_RESERVED = 3'b011
  } req_sel_e;

  // serial flags from the two async serial ports
  typedef struct packed {
    logic [1:0] rx_data_full;
    logic [1:0] tx_data_empty;
  } serial_flags_s;

  // byte in flight, tagged with the channel that moves it
  typedef struct packed {
    logic ch;
    logic [7:0] data;
  } xfer_s;

  localparam int XFER_BITS = $bits(xfer_s);

endpackage : dma_sel_pkg
`default_nettype wire

// ### rtl/dma_sel_fifo.sv
`default_nettype none
module dma_sel_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic in_valid, // producer has a word
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word to store
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // consumer takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] level_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_next

  assign in_ready = (level_r != DEPTH_CNT);
  assign out_valid = (level_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_next(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_next(rd_ptr_r);
      end
      if (push && !pop) begin
        level_r <= level_r + (PW + 1)'(1);
      end else if (pop && !push) begin
        level_r <= level_r - (PW + 1)'(1);
      end
    end
  end

endmodule : dma_sel_fifo
`default_nettype wire

// ### rtl/dma_address_count_request_select.sv
`default_nettype none
// Summary of operation
// - ch0 source address: 20 bits, 1 MB memory or 64 KB I/O
// - ch0 I/O source: bank bits 1-0 pick pin 0, serial receive-full
// - ch0 I/O destination: bank bits 1-0 pick pin 0, serial transmit
// - ch0 destination address: 20 bits, memory or I/O
// - 16-bit byte counters count down one per byte moved
// - byte counters have no reset
// - ch1 memory address: 20 bits, source or destination
// - ch1 I/O address is two bytes; third byte holds select and alternation
// - alternation: ch0 end sets current bit, handing over to ch1
// - alternation: ch1 end clears current bit, handing back to ch0
// - alternation off: current bit has no effect
// - alternation on, current bit 0: ch1 request withheld
// - alternation on, current bit 1: ch0 request withheld
// - software writes current bit only while both channels stopped
// - ch1 I/O source: select picks pin 1 or serial receive-full
// - ch1 I/O destination: 000 pin 1, 001/010 serial transmit-empty
// - count reaching zero ends transfer, clears enable, raises enabled interrupt
module dma_address_count_request_select
  import dma_sel_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int DATA_BITS = 8
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] io_addr, // internal I/O address
  input wire logic io_wr, // write strobe, one cycle
  input wire logic io_rd, // read strobe, one cycle
  input wire logic [7:0] io_wdata, // write data
  output logic [7:0] io_rdata, // read data, valid cycle after io_rd
  input wire logic ext_dma_request_0, // external request pin 0
  input wire logic ext_dma_request_1, // external request pin 1
  input wire dma_sel_pkg::serial_flags_s serial_flags, // async serial port flags
  input wire logic ch0_src_io, // channel 0 source is I/O
  input wire logic ch0_dst_io, // channel 0 destination is I/O
  input wire logic ch1_io_direction, // 1: channel 1 I/O is the source
  input wire logic [1:0] enable_set, // start pulse per channel
  input wire logic [1:0] enable_clr, // stop pulse per channel
  input wire logic [1:0] irq_enable, // termination interrupt enables
  output logic ch0_enable, // channel 0 running
  output logic ch1_enable, // channel 1 running
  output logic [1:0] dma_request, // gated request per channel
  output logic [1:0] term_irq, // termination interrupt, level
  output logic [ADDR_BITS-1:0] ch0_src_addr, // channel 0 source address
  output logic [ADDR_BITS-1:0] ch0_dst_addr, // channel 0 destination address
  output logic [ADDR_BITS-1:0] ch1_mem_addr, // channel 1 memory address
  output logic [15:0] ch1_io_addr, // channel 1 I/O address
  input wire logic xfer_in_valid, // a read byte is offered
  output logic xfer_in_ready, // buffer has room
  input wire dma_sel_pkg::xfer_s xfer_in, // read byte with channel tag
  output logic xfer_out_valid, // byte ready to write
  input wire logic xfer_out_ready, // writer accepts the byte
  output dma_sel_pkg::xfer_s xfer_out // byte to write
);
  import dma_sel_pkg::*;

  // ------------------------
  // storage
  // ------------------------
  logic [7:0] src0_low_r;
  logic [7:0] src0_high_r;
  logic [BANK_BITS-1:0] src0_bank_r;
  logic [7:0] dst0_low_r;
  logic [7:0] dst0_high_r;
  logic [BANK_BITS-1:0] dst0_bank_r;
  logic [7:0] mem1_low_r;
  logic [7:0] mem1_high_r;
  logic [BANK_BITS-1:0] mem1_bank_r;
  logic [7:0] io1_low_r;
  logic [7:0] io1_high_r;
  logic alt_enable_r;
  logic alternate_current_channel_r;
  logic tout_sel_r;
  logic [SEL_MSB:0] ch1_request_select_r;
  logic [COUNT_BITS-1:0] count_r [2];
  logic [1:0] enable_r;
  logic [1:0] irq_r;
  logic [7:0] rdata_r;

  logic [7:0] rdata_nxt;
  logic [1:0] byte_moved;
  logic [1:0] chan_end;
  logic [1:0] raw_req;
  logic [DATA_BITS:0] fifo_out;

  // ------------------------
  // helpers
  // ------------------------
  // pin or serial flag chosen by a select code; reserved codes never request
  function automatic logic pick_request(input logic [2:0] code, input logic pin,
                                        input logic [1:0] flags);
    case (code)
      SEL_EXT_PIN: pick_request = pin;
      SEL_SERIAL0: pick_request = flags[0];
      SEL_SERIAL1: pick_request = flags[1];
      default: pick_request = 1'b0;
    endcase
  endfunction : pick_request

  function automatic logic hit(input logic [7:0] ofs);
    hit = io_wr && (io_addr == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // byte buffer between read and write halves of a transfer
  // ---------------------------------------------------------------
  dma_sel_fifo #(
    .WIDTH(DATA_BITS + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(xfer_in_valid),
    .in_ready(xfer_in_ready),
    .in_data(xfer_in),
    .out_valid(xfer_out_valid),
    .out_ready(xfer_out_ready),
    .out_data(fifo_out)
  );
  assign xfer_out = fifo_out;

  // a byte counts as moved once the writer takes it
  always_comb begin
    byte_moved = 2'b00;
    if (xfer_out_valid && xfer_out_ready) begin
      byte_moved[fifo_out[DATA_BITS]] = 1'b1;
    end
  end

  // last byte: count steps from one to zero
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      chan_end[c] = byte_moved[c] && (count_r[c] == COUNT_BITS'(1));
    end
  end

  // ------------------------
  // channel 0 address registers
  // ------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src0_low_r <= ADDR_BYTE_RST;
      src0_high_r <= ADDR_BYTE_RST;
      src0_bank_r <= ADDR_BYTE_RST[BANK_BITS-1:0];
      dst0_low_r <= ADDR_BYTE_RST;
      dst0_high_r <= ADDR_BYTE_RST;
      dst0_bank_r <= ADDR_BYTE_RST[BANK_BITS-1:0];
    end else begin
      if (hit(SRC0_LOW_OFS)) begin
        src0_low_r <= io_wdata;
      end
      if (hit(SRC0_HIGH_OFS)) begin
        src0_high_r <= io_wdata;
      end
      if (hit(SRC0_BANK_OFS)) begin
        src0_bank_r <= io_wdata[BANK_BITS-1:0];
      end
      if (hit(DST0_LOW_OFS)) begin
        dst0_low_r <= io_wdata;
      end
      if (hit(DST0_HIGH_OFS)) begin
        dst0_high_r <= io_wdata;
      end
      if (hit(DST0_BANK_OFS)) begin
        dst0_bank_r <= io_wdata[BANK_BITS-1:0];
      end
    end
  end

  assign ch0_src_addr = {src0_bank_r, src0_high_r, src0_low_r};
  assign ch0_dst_addr = {dst0_bank_r, dst0_high_r, dst0_low_r};

  // ------------------------
  // channel 1 address registers
  // ------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem1_low_r <= ADDR_BYTE_RST;
      mem1_high_r <= ADDR_BYTE_RST;
      mem1_bank_r <= ADDR_BYTE_RST[BANK_BITS-1:0];
      io1_low_r <= ADDR_BYTE_RST;
      io1_high_r <= ADDR_BYTE_RST;
    end else begin
      if (hit(MEM1_LOW_OFS)) begin
        mem1_low_r <= io_wdata;
      end
      if (hit(MEM1_HIGH_OFS)) begin
        mem1_high_r <= io_wdata;
      end
      if (hit(MEM1_BANK_OFS)) begin
        mem1_bank_r <= io_wdata[BANK_BITS-1:0];
      end
      if (hit(IO1_LOW_OFS)) begin
        io1_low_r <= io_wdata;
      end
      if (hit(IO1_HIGH_OFS)) begin
        io1_high_r <= io_wdata;
      end
    end
  end

  assign ch1_mem_addr = {mem1_bank_r, mem1_high_r, mem1_low_r};
  assign ch1_io_addr = {io1_high_r, io1_low_r};

  // ------------------------
  // request control byte and alternation
  // ------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_enable_r <= REQ_CTRL_RST[ALT_ENABLE_BIT];
      tout_sel_r <= REQ_CTRL_RST[TOUT_SEL_BIT];
      ch1_request_select_r <= REQ_CTRL_RST[SEL_MSB:0];
    end else if (hit(REQ_CTRL_OFS)) begin
      alt_enable_r <= io_wdata[ALT_ENABLE_BIT];
      tout_sel_r <= io_wdata[TOUT_SEL_BIT];
      ch1_request_select_r <= io_wdata[SEL_MSB:0];
    end
  end

  // with alternation on, a channel end in the same cycle as a write wins over the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alternate_current_channel_r <= REQ_CTRL_RST[ALT_CURRENT_BIT];
    end else if (alt_enable_r && chan_end[0]) begin
      alternate_current_channel_r <= 1'b1;
    end else if (alt_enable_r && chan_end[1]) begin
      alternate_current_channel_r <= 1'b0;
    end else if (hit(REQ_CTRL_OFS)) begin
      alternate_current_channel_r <= io_wdata[ALT_CURRENT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // byte counters: deliberately without reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (byte_moved[c]) begin
        count_r[c] <= count_r[c] - COUNT_BITS'(1);
      end
    end
    if (hit(CNT0_LOW_OFS)) begin
      count_r[0][7:0] <= io_wdata;
    end
    if (hit(CNT0_HIGH_OFS)) begin
      count_r[0][15:8] <= io_wdata;
    end
    if (hit(CNT1_LOW_OFS)) begin
      count_r[1][7:0] <= io_wdata;
    end
    if (hit(CNT1_HIGH_OFS)) begin
      count_r[1][15:8] <= io_wdata;
    end
  end

  // ---------------------------------------------------------------
  // channel enables and termination flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (chan_end[c]) begin
          enable_r[c] <= 1'b0;
        end else if (enable_set[c]) begin
          enable_r[c] <= 1'b1;
        end else if (enable_clr[c]) begin
          enable_r[c] <= 1'b0;
        end
      end
    end
  end

  // held until the channel is started again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (chan_end[c]) begin
          irq_r[c] <= 1'b1;
        end else if (enable_set[c]) begin
          irq_r[c] <= 1'b0;
        end
      end
    end
  end

  assign ch0_enable = enable_r[0];
  assign ch1_enable = enable_r[1];
  assign term_irq = irq_r & irq_enable;

  // ---------------------------------------------------------------
  // request selection
  // ---------------------------------------------------------------
  always_comb begin
    // memory-only channel 0 has no handshake and runs on its own
    raw_req[0] = 1'b1;
    if (ch0_src_io) begin
      raw_req[0] = pick_request({1'b0, src0_bank_r[1:0]}, ext_dma_request_0,
                                serial_flags.rx_data_full);
    end else if (ch0_dst_io) begin
      raw_req[0] = pick_request({1'b0, dst0_bank_r[1:0]}, ext_dma_request_0,
                                serial_flags.tx_data_empty);
    end
    if (ch1_io_direction) begin
      raw_req[1] = pick_request(ch1_request_select_r, ext_dma_request_1,
                                serial_flags.rx_data_full);
    end else begin
      raw_req[1] = pick_request(ch1_request_select_r, ext_dma_request_1,
                                serial_flags.tx_data_empty);
    end
  end

  // the pin shared by both channels relies on board wiring
  assign dma_request[0] = enable_r[0] && raw_req[0]
                          && !(alt_enable_r && alternate_current_channel_r);
  assign dma_request[1] = enable_r[1] && raw_req[1]
                          && !(alt_enable_r && !alternate_current_channel_r);

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  always_comb begin
    if (io_addr == SRC0_LOW_OFS) begin
      rdata_nxt = src0_low_r;
    end else if (io_addr == SRC0_HIGH_OFS) begin
      rdata_nxt = src0_high_r;
    end else if (io_addr == SRC0_BANK_OFS) begin
      rdata_nxt = {4'h0, src0_bank_r};
    end else if (io_addr == DST0_LOW_OFS) begin
      rdata_nxt = dst0_low_r;
    end else if (io_addr == DST0_HIGH_OFS) begin
      rdata_nxt = dst0_high_r;
    end else if (io_addr == DST0_BANK_OFS) begin
      rdata_nxt = {4'h0, dst0_bank_r};
    end else if (io_addr == CNT0_LOW_OFS) begin
      rdata_nxt = count_r[0][7:0];
    end else if (io_addr == CNT0_HIGH_OFS) begin
      rdata_nxt = count_r[0][15:8];
    end else if (io_addr == MEM1_LOW_OFS) begin
      rdata_nxt = mem1_low_r;
    end else if (io_addr == MEM1_HIGH_OFS) begin
      rdata_nxt = mem1_high_r;
    end else if (io_addr == MEM1_BANK_OFS) begin
      rdata_nxt = {4'h0, mem1_bank_r};
    end else if (io_addr == IO1_LOW_OFS) begin
      rdata_nxt = io1_low_r;
    end else if (io_addr == IO1_HIGH_OFS) begin
      rdata_nxt = io1_high_r;
    end else if (io_addr == REQ_CTRL_OFS) begin
      rdata_nxt = {alt_enable_r, alternate_current_channel_r, 2'b00, tout_sel_r,
                   ch1_request_select_r};
    end else if (io_addr == CNT1_LOW_OFS) begin
      rdata_nxt = count_r[1][7:0];
    end else if (io_addr == CNT1_HIGH_OFS) begin
      rdata_nxt = count_r[1][15:8];
    end else begin
      rdata_nxt = RDATA_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RDATA_RST;
    end else if (io_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign io_rdata = rdata_r;

endmodule : dma_address_count_request_select
`default_nettype wire

// ### sim/dma_sel_checker_assertions.sv
`default_nettype none
module dma_sel_checker
  import dma_sel_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [7:0] io_addr, // addr
  input wire logic io_wr, // write
  input wire logic [7:0] io_wdata, // data
  input wire logic ext_dma_request_0, // pin 0
  input wire dma_sel_pkg::serial_flags_s serial_flags, // flags
  input wire logic ch0_src_io, // src io
  input wire logic ch0_dst_io, // dst io
  input wire logic ch1_io_direction, // ch1 dir
  input wire logic ch0_enable, // ch0 on
  input wire logic ch1_enable, // ch1 on
  input wire logic [1:0] dma_request, // requests
  input wire logic [ADDR_BITS-1:0] ch0_src_addr, // src
  input wire logic [ADDR_BITS-1:0] ch0_dst_addr, // dst
  input wire logic [ADDR_BITS-1:0] ch1_mem_addr, // mem
  input wire logic [15:0] ch1_io_addr, // io
  input wire logic xfer_in_valid, // push
  input wire logic xfer_in_ready, // room
  input wire logic xfer_out_valid, // held
  input wire logic xfer_out_ready // pop
);
  // ----------------------------------------
  // shadows: only software moves alt_r and sel_r; fill_r tracks buffer fill
  // ----------------------------------------
  logic alt_r;
  logic [2:0] sel_r;
  logic [2:0] fill_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_r <= 1'h0;
      sel_r <= 3'h0;
    end else if (io_wr && io_addr == REQ_CTRL_OFS) begin
      alt_r <= io_wdata[ALT_ENABLE_BIT];
      sel_r <= io_wdata[2:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fill_r <= 3'h0;
    else fill_r <= fill_r + 3'(xfer_in_valid && xfer_in_ready)
                   - 3'(xfer_out_valid && xfer_out_ready);
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_src_bank_store: assert property (io_wr && io_addr == SRC0_BANK_OFS |=>
    ch0_src_addr[19:16] == 4'($past(io_wdata))) else $error("src bank lost");
  a_dst_high_store: assert property (io_wr && io_addr == DST0_HIGH_OFS |=>
    ch0_dst_addr[15:8] == $past(io_wdata)) else $error("dst high lost");
  a_mem_bank_store: assert property (io_wr && io_addr == MEM1_BANK_OFS |=>
    ch1_mem_addr[19:16] == 4'($past(io_wdata))) else $error("mem bank lost");
  a_io_high_store: assert property (io_wr && io_addr == IO1_HIGH_OFS |=>
    ch1_io_addr[15:8] == $past(io_wdata)) else $error("io high lost");
  a_ch0_pin_path: assert property (!alt_r && ch0_enable && ch0_src_io &&
    ch0_src_addr[17:16] == 2'h0 |-> dma_request[0] == ext_dma_request_0)
    else $error("ch0 pin path wrong");
  a_ch0_tx_path: assert property (!alt_r && ch0_enable && !ch0_src_io && ch0_dst_io &&
    ch0_dst_addr[17:16] == 2'h1 |-> dma_request[0] == serial_flags.tx_data_empty[0])
    else $error("ch0 tx path wrong");
  a_ch1_rx_path: assert property (!alt_r && ch1_enable && ch1_io_direction &&
    sel_r == 3'h2 |-> dma_request[1] == serial_flags.rx_data_full[1])
    else $error("ch1 rx path wrong");
  a_ch1_reserved_quiet: assert property (sel_r > 3'h2 |-> !dma_request[1])
    else $error("reserved code requests");
  a_buffer_full_refuse: assert property (fill_r == 3'(FIFO_DEPTH) |-> !xfer_in_ready)
    else $error("full buffer accepts");
  c_buffer_full: cover property (fill_r == 3'(FIFO_DEPTH));
  c_handover: cover property (alt_r && $fell(ch0_enable));
  c_both_request: cover property (dma_request == 2'h3);
endmodule : dma_sel_checker
bind dma_address_count_request_select dma_sel_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (.*);
`default_nettype wire

// ### sim/dma_peer_model.sv
`default_nettype none
module dma_peer_model
  import dma_sel_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [1:0] pin_cmd, // requester levels
  input wire logic shared, // one requester on both pins
  input wire dma_sel_pkg::serial_flags_s flag_cmd, // port flags
  input wire logic stall, // writer busy
  output logic ext_dma_request_0, // pin 0
  output logic ext_dma_request_1, // pin 1
  output dma_sel_pkg::serial_flags_s serial_flags, // to block
  input wire logic xfer_out_valid, // byte held
  output logic xfer_out_ready, // writer takes
  input wire dma_sel_pkg::xfer_s xfer_out, // byte
  output logic [7:0] last_byte, // latest taken
  output logic [3:0] taken // bytes taken
);
  // ----------------------------------------
  // requesters and byte writer
  // ----------------------------------------
  assign ext_dma_request_0 = pin_cmd[0];
  assign ext_dma_request_1 = shared ? pin_cmd[0] : pin_cmd[1];
  assign serial_flags = flag_cmd;
  assign xfer_out_ready = !stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 4'h0;
      last_byte <= 8'h00;
    end else if (xfer_out_valid && !stall) begin
      taken <= taken + 4'h1;
      last_byte <= xfer_out.data;
    end
  end
endmodule : dma_peer_model
`default_nettype wire

// ### sim/dma_address_count_request_select_tb_top.sv
`default_nettype none
module dma_address_count_request_select_tb_top
  import dma_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, io_wr = 1'h0, io_rd = 1'h0, shared = 1'h0, stall = 1'h1;
  logic ch0_src_io = 1'h0, ch0_dst_io = 1'h0, ch1_io_direction = 1'h0, xfer_in_valid = 1'h0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, last_byte;
  logic [1:0] enable_set = 2'h0, enable_clr = 2'h0, irq_enable = 2'h3, pin_cmd = 2'h0;
  logic [1:0] dma_request, term_irq;
  logic ext_dma_request_0, ext_dma_request_1, ch0_enable, ch1_enable;
  logic xfer_in_ready, xfer_out_valid, xfer_out_ready;
  logic [ADDR_BITS-1:0] ch0_src_addr, ch0_dst_addr, ch1_mem_addr;
  logic [15:0] ch1_io_addr;
  logic [3:0] taken;
  serial_flags_s flag_cmd = 4'h0, serial_flags;
  xfer_s xfer_in = 9'h000, xfer_out;
  int err_count = 0, compares = 0;
  dma_address_count_request_select dut (.*);
  dma_peer_model peer (.*);
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // strobes drop one edge before the next call may raise them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'h1;
    tick();
    io_wr = 1'h0;
    tick();
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    io_addr = a;
    io_rd = 1'h1;
    tick();
    io_rd = 1'h0;
    chk(io_rdata, e);
    tick();
  endtask : rd_chk
  task automatic pulse(input logic [1:0] s, input logic [1:0] c);
    enable_set = s;
    enable_clr = c;
    tick();
    enable_set = 2'h0;
    enable_clr = 2'h0;
    tick();
  endtask : pulse
  task automatic push(input logic c, input logic [7:0] d);
    xfer_in = {c, d};
    xfer_in_valid = 1'h1;
    for (int i = 0; i < 50 && !xfer_in_ready; i++) tick();
    chk(20'(xfer_in_ready), 20'h1);
    tick();
    xfer_in_valid = 1'h0;
    tick();
  endtask : push
  // k: 0 pin 0, 1 serial 0, 2 serial 1, 3 pin 1; the other flag set is inverted
  task automatic only(input int k, input logic rx);
    logic [1:0] r;
    r = {k == 2, k == 1};
    pin_cmd = {k == 3, k == 0};
    flag_cmd = rx ? {r, ~r} : {~r, r};
    tick();
  endtask : only
  function automatic logic [7:0] pat(input int i);
    return 8'(8'h3c + i * 39);
  endfunction : pat
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] m;
    rd_chk(REQ_CTRL_OFS, REQ_CTRL_RST);
    for (int i = 0; i < 16; i++) wr(SRC0_LOW_OFS + 8'(i), pat(i));
    for (int i = 0; i < 16; i++) begin
      m = (i == 2 || i == 5 || i == 10) ? 8'h0f : (i == 13 ? 8'hcf : 8'hff);
      rd_chk(SRC0_LOW_OFS + 8'(i), pat(i) & m);
    end
    chk(ch0_src_addr, 20'({pat(2), pat(1), pat(0)}));
    chk(ch0_dst_addr, 20'({pat(5), pat(4), pat(3)}));
    chk(ch1_mem_addr, 20'({pat(10), pat(9), pat(8)}));
    chk(20'(ch1_io_addr), 20'({pat(12), pat(11)}));
    wr(8'h1f, 8'hff);
    rd_chk(8'h1f, 8'h00);
  endtask : t_regs
  task automatic t_sel0();
    wr(REQ_CTRL_OFS, 8'h00);
    pulse(2'h1, 2'h0);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        ch0_src_io = (s == 0);
        ch0_dst_io = (s == 1);
        wr(s ? DST0_BANK_OFS : SRC0_BANK_OFS, 8'(c));
        for (int k = 0; k < 4; k++) begin
          only(k, s == 0);
          chk(20'(dma_request[0]), 20'(k == c && c < 3));
        end
      end
    end
    pulse(2'h0, 2'h1);
  endtask : t_sel0
  task automatic t_sel1();
    pulse(2'h2, 2'h0);
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 8; c++) begin
        ch1_io_direction = (d == 1);
        wr(REQ_CTRL_OFS, 8'(c));
        for (int k = 0; k < 4; k++) begin
          only(k, d == 1);
          chk(20'(dma_request[1]), 20'(c < 3 && k == (c == 0 ? 3 : c)));
        end
      end
    end
    pulse(2'h0, 2'h2);
  endtask : t_sel1
  task automatic t_buffer();
    wr(CNT1_LOW_OFS, 8'h05);
    wr(CNT1_HIGH_OFS, 8'h00);
    pulse(2'h2, 2'h0);
    for (int i = 0; i < 4; i++) push(1'h1, 8'h10 + 8'(i));
    chk(20'(xfer_in_ready), 20'h0);
    stall = 1'h0;
    repeat (6) tick();
    chk(20'(taken), 20'h4);
    chk(20'(last_byte), 20'h13);
    chk(20'(ch1_enable), 20'h1);
    push(1'h1, 8'h14);
    repeat (3) tick();
    chk(20'(ch1_enable), 20'h0);
    chk(20'(term_irq), 20'h2);
    irq_enable = 2'h1;
    tick();
    chk(20'(term_irq), 20'h0);
  endtask : t_buffer
  task automatic t_alternate();
    wr(CNT0_LOW_OFS, 8'h01);
    wr(CNT0_HIGH_OFS, 8'h00);
    wr(CNT1_LOW_OFS, 8'h01);
    ch0_src_io = 1'h0;
    ch0_dst_io = 1'h1;
    ch1_io_direction = 1'h0;
    wr(DST0_BANK_OFS, 8'h00);
    wr(REQ_CTRL_OFS, 8'h80);
    shared = 1'h1;
    only(0, 1'h0);
    pulse(2'h3, 2'h0);
    chk(20'(dma_request), 20'h1);
    push(1'h0, 8'h21);
    repeat (3) tick();
    chk(20'(ch0_enable), 20'h0);
    pulse(2'h1, 2'h0);
    chk(20'(dma_request), 20'h2);
    rd_chk(REQ_CTRL_OFS, 8'hc0);
    push(1'h1, 8'h22);
    repeat (3) tick();
    rd_chk(REQ_CTRL_OFS, 8'h80);
    chk(20'(dma_request), 20'h1);
    pulse(2'h0, 2'h1);
    wr(REQ_CTRL_OFS, 8'h40);
    rd_chk(REQ_CTRL_OFS, 8'h40);
    pulse(2'h3, 2'h0);
    chk(20'(dma_request), 20'h3);
  endtask : t_alternate
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'h1;
    tick();
    t_regs();
    t_sel0();
    t_sel1();
    t_buffer();
    t_alternate();
    stop_test();
  end
  initial begin
    #(50 * 4000);
    err_count++;
    stop_test();
  end
endmodule : dma_address_count_request_select_tb_top
`default_nettype wire
